// ### common/csx_pkg.sv
/*
 * csx_pkg: constants shared by the instruction execution slice.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package csx_pkg;
   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] CSX_OFS_OPERAND = 8'h00;
   localparam logic [7:0] CSX_OFS_COMMAND = 8'h04;
   localparam logic [7:0] CSX_OFS_ACC     = 8'h08;
   localparam logic [7:0] CSX_OFS_STATUS  = 8'h0C;
   localparam logic [7:0] CSX_OFS_FILE    = 8'h10;
   localparam logic [7:0] CSX_OFS_WAKE    = 8'h14;
   localparam logic [7:0] CSX_OFS_WDOG    = 8'h18;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CSX_OPR_K_LSB   = 0;
   localparam int CSX_OPR_F_LSB   = 8;
   localparam int CSX_OPR_D_BIT   = 16;
   localparam int CSX_ST_C        = 0;
   localparam int CSX_ST_DC       = 1;
   localparam int CSX_ST_Z        = 2;
   localparam int CSX_ST_SLEEP_ENTERED_N = 3;
   localparam int CSX_ST_WD_EXPIRY_N     = 4;
   localparam int CSX_ST_ASLEEP   = 5;
   localparam int CSX_WD_PRE_LSB  = 8;

   // ************************************************************
   // reset values and sizes
   // ************************************************************
   localparam logic [7:0]  CSX_ACC_RST     = 8'h00;
   localparam logic [16:0] CSX_OPERAND_RST = 17'h0_0000;
   localparam logic [7:0]  CSX_WDOG_CLR    = 8'h00;
   localparam int          CSX_DATA_W      = 8;
   localparam int          CSX_FILE_DEPTH  = 128;
   localparam int          CSX_FADDR_W     = 7;

   // ************************************************************
   // operation codes, written to the command register
   // ************************************************************
   typedef enum logic [2:0] {
      CSX_OP_NONE    = 3'h0,
      CSX_OP_SLEEP   = 3'h1,
      CSX_OP_RRC     = 3'h2,
      CSX_OP_LIT_SUB = 3'h3,
      CSX_OP_FIL_SUB = 3'h4,
      CSX_OP_XOR_F   = 3'h5,
      CSX_OP_XOR_L   = 3'h6,
      CSX_OP_NIB_X   = 3'h7
   } csx_op_e;

   // core power state
   typedef enum logic {
      CSX_AWAKE  = 1'b0,
      CSX_ASLEEP = 1'b1
   } csx_state_e;
endpackage

// ### verilog/csx_file_ram.sv
/*
 * csx_file_ram: file register storage, flip-flops addressed by index.
 * Assumes one write per cycle; read is combinational.
 */
`timescale 1ns/100ps
module csx_file_ram
   import csx_pkg::*;
#(
   parameter int WIDTH = CSX_DATA_W,
   parameter int DEPTH = CSX_FILE_DEPTH,
   parameter int AW    = CSX_FADDR_W
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   // storage clears on reset so reads are never undefined
   always_ff @(posedge mclk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (!reset_n) begin
            mem_reg[i] <= '0;
         end else if (wr_en && (int'(addr) == i)) begin
            mem_reg[i] <= wr_data;
         end
      end
   end

   // asynchronous read by index
   assign rd_data = mem_reg[addr];
endmodule // csx_file_ram

// ### verilog/csx_alu.sv
/*
 * csx_alu: combinational result and flag logic for the operations.
 * Assumes operands are stable for the cycle in which the op executes.
 */
`timescale 1ns/100ps
module csx_alu
   import csx_pkg::*;
(
   input  wire csx_op_e    op,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] fval,
   input  wire logic [7:0] lit,
   input  wire logic       c_in,
   output logic      [7:0] result,
   output logic            c_out,
   output logic            dc_out,
   output logic            z_out,
   output logic            upd_c,
   output logic            upd_dc,
   output logic            upd_z,
   output logic            has_result,
   output logic            file_op
);
   // ************************************************************
   // helpers
   // ************************************************************
   // two's complement a - b: {carry (no borrow), digit carry, diff}
   function automatic logic [9:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, ~b} + 9'h001;
      low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      return {full[8], low[4], full[7:0]};
   endfunction

   logic [9:0] sub_lit;
   logic [9:0] sub_fil;

   assign sub_lit = sub_flags(lit, acc);
   assign sub_fil = sub_flags(fval, acc);

   // ************************************************************
   // result and flag select
   // ************************************************************
   always_comb begin
      result = 8'h00;
      c_out  = c_in;
      dc_out = 1'b0;
      upd_c  = 1'b0;
      upd_dc = 1'b0;
      upd_z  = 1'b0;
      has_result = 1'b1;
      file_op    = 1'b1;
      unique case (op)
         CSX_OP_RRC: begin
            result = {c_in, fval[7:1]};
            c_out  = fval[0];
            upd_c  = 1'b1;
         end
         CSX_OP_LIT_SUB: begin
            {c_out, dc_out, result} = sub_lit;
            {upd_c, upd_dc, upd_z}  = 3'b111;
            file_op = 1'b0;
         end
         CSX_OP_FIL_SUB: begin
            {c_out, dc_out, result} = sub_fil;
            {upd_c, upd_dc, upd_z}  = 3'b111;
         end
         CSX_OP_XOR_F: begin
            result = acc ^ fval;
            upd_z  = 1'b1;
         end
         CSX_OP_XOR_L: begin
            result  = acc ^ lit;
            upd_z   = 1'b1;
            file_op = 1'b0;
         end
         CSX_OP_NIB_X: begin
            result = {fval[3:0], fval[7:4]};
         end
         CSX_OP_NONE, CSX_OP_SLEEP: begin
            has_result = 1'b0;
            file_op    = 1'b0;
         end
      endcase
   end

   // zero flag from the 8-bit result
   assign z_out = (result == 8'h00);
endmodule // csx_alu

// ### verilog/csx_core.sv
/*
 * csx_core: AHB-Lite reachable execution slice for sleep, rotate right
 * through carry, subtract, exclusive OR and nibble exchange.
 * Assumes one AHB-Lite master, hready fed back from hreadyout, and a
 * synchronous active-low reset.
 */
`timescale 1ns/100ps
// Operation
// - sleep clears watchdog, prescaler; timeout 1, powerdown 0
// - after sleep, halt; no instruction until wake
// - rotate right through carry, only carry changes
// - destination bit picks accumulator or file register
// - literal minus accumulator into accumulator, C DC Z
// - file minus accumulator to destination, C DC Z
// - nibble exchange to destination, flags untouched
// - accumulator xor file to destination, zero only
// - accumulator xor literal into accumulator, zero only
module csx_core
   import csx_pkg::*;
#(
   parameter int WD_PRE_W = 8,
   parameter int WD_CNT_W = 8
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   output logic             osc_halted
);
   // ************************************************************
   // declarations
   // ************************************************************
   logic                  wr_pend_reg;
   logic                  rd_pend_reg;
   logic [7:0]            addr_reg;
   logic [31:0]           hrdata_reg;
   logic [16:0]           operand_reg;
   logic [7:0]            acc_reg;
   logic [7:0]            acc_next;
   logic                  c_reg;
   logic                  dc_reg;
   logic                  z_reg;
   logic                  sleep_entered_flag_n_reg;
   logic                  watchdog_expiry_flag_n_reg;
   csx_state_e            state_reg;
   csx_state_e            state_next;
   logic [WD_PRE_W-1:0]   wd_pre_reg;
   logic [WD_CNT_W-1:0]   wd_cnt_reg;
   logic                  addr_ok;
   logic                  wr_operand;
   logic                  wr_command;
   logic                  wr_acc;
   logic                  wr_status;
   logic                  wr_file;
   logic                  wr_wake;
   logic                  exec;
   logic                  exec_sleep;
   logic                  wd_ovf;
   logic                  wake;
   csx_op_e               op_w;
   logic [7:0]            lit_w;
   logic [6:0]            faddr_w;
   logic                  dest_w;
   logic [7:0]            fval_w;
   logic [7:0]            alu_res;
   logic                  alu_c;
   logic                  alu_dc;
   logic                  alu_z;
   logic                  upd_c;
   logic                  upd_dc;
   logic                  upd_z;
   logic                  has_res;
   logic                  file_op;
   logic                  to_file;
   logic                  to_acc;
   logic                  ram_we;
   logic [7:0]            ram_wdata;
   logic [31:0]           rd_mux;

   // ************************************************************
   // bus slave: address phase capture, one wait state on reads
   // ************************************************************
   assign addr_ok = hsel && htrans[1] && hready;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         rd_pend_reg <= addr_ok && !hwrite;
         if (addr_ok) begin
            addr_reg <= haddr[7:0];
         end
         if (rd_pend_reg) begin
            hrdata_reg <= rd_mux;
         end
      end
   end

   // the wait state gives time to load the registered read data, hrdata_reg
   assign hreadyout = !rd_pend_reg;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   // write strobes, data phase; unmapped writes are dropped
   assign wr_operand = wr_pend_reg && (addr_reg == CSX_OFS_OPERAND);
   assign wr_command = wr_pend_reg && (addr_reg == CSX_OFS_COMMAND);
   assign wr_acc     = wr_pend_reg && (addr_reg == CSX_OFS_ACC);
   assign wr_status  = wr_pend_reg && (addr_reg == CSX_OFS_STATUS);
   assign wr_file    = wr_pend_reg && (addr_reg == CSX_OFS_FILE);
   assign wr_wake    = wr_pend_reg && (addr_reg == CSX_OFS_WAKE);

   // read select; unmapped reads return zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr_reg)
         CSX_OFS_OPERAND: rd_mux[16:0] = operand_reg;
         CSX_OFS_COMMAND: rd_mux       = 32'h0000_0000;
         CSX_OFS_ACC:     rd_mux[7:0]  = acc_reg;
         CSX_OFS_STATUS:  rd_mux[5:0]  = {state_reg == CSX_ASLEEP,
                                           watchdog_expiry_flag_n_reg,
                                           sleep_entered_flag_n_reg,
                                           z_reg, dc_reg, c_reg};
         CSX_OFS_FILE:    rd_mux[7:0]  = fval_w;
         CSX_OFS_WDOG:    rd_mux[CSX_WD_PRE_LSB +: WD_PRE_W] = wd_pre_reg;
         default:         rd_mux       = 32'h0000_0000;
      endcase
      if (addr_reg == CSX_OFS_WDOG) begin
         rd_mux[WD_CNT_W-1:0] = wd_cnt_reg;
      end
   end

   // ************************************************************
   // operand fields and execution
   // ************************************************************
   assign lit_w   = operand_reg[CSX_OPR_K_LSB +: 8];
   assign faddr_w = operand_reg[CSX_OPR_F_LSB +: 7];
   assign dest_w  = operand_reg[CSX_OPR_D_BIT];
   assign op_w    = csx_op_e'(hwdata[2:0]);

   // a halted core ignores commands until woken
   assign exec       = wr_command && (state_reg == CSX_AWAKE);
   assign exec_sleep = exec && (op_w == CSX_OP_SLEEP);

   csx_alu u_csx_alu (
      .op         (op_w),
      .acc        (acc_reg),
      .fval       (fval_w),
      .lit        (lit_w),
      .c_in       (c_reg),
      .result     (alu_res),
      .c_out      (alu_c),
      .dc_out     (alu_dc),
      .z_out      (alu_z),
      .upd_c      (upd_c),
      .upd_dc     (upd_dc),
      .upd_z      (upd_z),
      .has_result (has_res),
      .file_op    (file_op)
   );

   // destination steering
   assign to_file   = exec && has_res && file_op && dest_w;
   assign to_acc    = exec && has_res && !(file_op && dest_w);
   assign ram_we    = to_file || wr_file;
   assign ram_wdata = to_file ? alu_res : hwdata[7:0];
   assign acc_next  = to_acc ? alu_res : (wr_acc ? hwdata[7:0] : acc_reg);

   csx_file_ram u_csx_file_ram (
      .mclk    (mclk),
      .reset_n (reset_n),
      .wr_en   (ram_we),
      .addr    (faddr_w),
      .wr_data (ram_wdata),
      .rd_data (fval_w)
   );

   // operand, accumulator and arithmetic flags
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         operand_reg <= CSX_OPERAND_RST;
         acc_reg     <= CSX_ACC_RST;
         c_reg       <= 1'b0;
         dc_reg      <= 1'b0;
         z_reg       <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         if (wr_operand) begin
            operand_reg <= hwdata[16:0];
         end
         if (wr_status) begin
            {z_reg, dc_reg, c_reg} <= hwdata[CSX_ST_Z:CSX_ST_C];
         end else if (exec) begin
            if (upd_c)  c_reg  <= alu_c;
            if (upd_dc) dc_reg <= alu_dc;
            if (upd_z)  z_reg  <= alu_z;
         end
      end
   end

   // ************************************************************
   // watchdog and power state
   // ************************************************************
   // free running; overflow while asleep is a wake-up with timeout
   assign wd_ovf = (&wd_pre_reg) && (&wd_cnt_reg);
   assign wake   = wr_wake || wd_ovf;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wd_pre_reg <= '0;
         wd_cnt_reg <= '0;
      end else if (exec_sleep) begin
         wd_pre_reg <= '0;
         wd_cnt_reg <= '0;
      end else begin
         wd_pre_reg <= wd_pre_reg + 1'b1;
         if (&wd_pre_reg) wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
   end

   // sleep wins over a same-cycle overflow: it clears the counter too
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         watchdog_expiry_flag_n_reg <= 1'b1;
         sleep_entered_flag_n_reg   <= 1'b1;
      end else if (exec_sleep) begin
         watchdog_expiry_flag_n_reg <= 1'b1;
         sleep_entered_flag_n_reg   <= 1'b0;
      end else if (wd_ovf) begin
         watchdog_expiry_flag_n_reg <= 1'b0;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CSX_AWAKE:  if (exec_sleep) state_next = CSX_ASLEEP;
         CSX_ASLEEP: if (wake)       state_next = CSX_AWAKE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) state_reg <= CSX_AWAKE;
      else          state_reg <= state_next;
   end

   assign osc_halted = (state_reg == CSX_ASLEEP);

   // ************************************************************
   // checks
   // ************************************************************
   logic [7:0] rrc_expect;
   logic [7:0] xorl_expect;
   logic       lit_ge_acc;

   assign rrc_expect  = {c_reg, fval_w[7:1]};
   assign xorl_expect = acc_reg ^ lit_w;
   assign lit_ge_acc  = (lit_w >= acc_reg);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_sleep_cmd;
      exec_sleep;
   endsequence
   sequence s_halted;
      state_reg == CSX_ASLEEP && osc_halted;
   endsequence

   AST_SLEEP_WDOG: assert property (s_sleep_cmd |=> wd_cnt_reg == '0 && wd_pre_reg == '0)
      else $error("sleep did not clear the watchdog");
   AST_SLEEP_FLAGS: assert property (s_sleep_cmd |=>
                                     watchdog_expiry_flag_n_reg && !sleep_entered_flag_n_reg)
      else $error("sleep did not set power status bits");
   AST_SLEEP_HALT: assert property (s_sleep_cmd |=> s_halted)
      else $error("core not halted after sleep");
   AST_HALT_HOLD: assert property (s_halted ##0 !wake |=> s_halted)
      else $error("core left sleep without a wake-up");
   AST_HALT_NO_EXEC: assert property (s_halted ##0 wr_command |=> $stable(acc_reg))
      else $error("instruction executed while halted");
   AST_RRC: assert property (exec && op_w == CSX_OP_RRC && !dest_w |=>
                             acc_reg == $past(rrc_expect) && c_reg == $past(fval_w[0]))
      else $error("rotate through carry wrong");
   AST_DEST_FILE: assert property (to_file |=> $stable(acc_reg) && fval_w == $past(alu_res))
      else $error("file destination not honoured");
   AST_LIT_SUB: assert property (exec && op_w == CSX_OP_LIT_SUB |=>
                                 c_reg == $past(lit_ge_acc))
      else $error("literal subtract carry wrong");
   AST_FIL_SUB_Z: assert property (exec && op_w == CSX_OP_FIL_SUB && !dest_w |=>
                                   z_reg == (acc_reg == 8'h00))
      else $error("file subtract zero flag wrong");
   AST_NIB_X: assert property (exec && op_w == CSX_OP_NIB_X |=>
                               $stable(c_reg) && $stable(dc_reg) && $stable(z_reg))
      else $error("nibble exchange changed a flag");
   AST_XOR_F: assert property (exec && op_w == CSX_OP_XOR_F |=>
                               $stable(c_reg) && $stable(dc_reg))
      else $error("xor with file changed carry");
   AST_XOR_L: assert property (exec && op_w == CSX_OP_XOR_L |=>
                               acc_reg == $past(xorl_expect) && z_reg == (acc_reg == 8'h00))
      else $error("xor with literal wrong");
endmodule // csx_core

// ### test/tb_cpu_sleep_sub_xor_swap_rotate_ops.sv
/*
 * tb_cpu_sleep_sub_xor_swap_rotate_ops: self-checking bench for csx_core,
 * reached over its AHB-Lite register port, with the osc_halted output also watched directly.
 * Assumes a lone slave whose hreadyout is fed back as hready.
 */
`timescale 1ns/100ps
module tb_cpu_sleep_sub_xor_swap_rotate_ops
   import csx_pkg::*;
;
   // ************************************************************
   // stimulus and observed signals
   // ************************************************************
   logic        mclk        = 1'b0;
   logic        reset_n     = 1'b0;
   logic        hsel        = 1'b0;
   logic [31:0] haddr       = 32'h0000_0000;
   logic [1:0]  htrans      = 2'b00;
   logic        hwrite      = 1'b0;
   logic [2:0]  hsize       = 3'b010;
   logic [31:0] hwdata      = 32'h0000_0000;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        osc_halted;
   logic [31:0] rdv;
   int          errors      = 0;
   int          check_count = 0;
   int          cycles      = 0;

   // small watchdog so overflow wake fits in a short run
   csx_core #(.WD_PRE_W(4), .WD_CNT_W(4)) u_csx_core (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hreadyout),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .osc_halted(osc_halted)
   );

   // 100 MHz clock
   always #5 mclk = ~mclk;

   // hang guard: far above the thousand or so cycles the tests need
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors = errors + 1;
         conclude();
      end
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count = check_count + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ready sampled at the rising edge; read data taken at that same edge
   task automatic wait_rdy();
      @(posedge mclk);
      while (hreadyout !== 1'b1) begin
         @(posedge mclk);
      end
      rdv = hrdata;
   endtask

   // one single-word transfer; read data left in rdv
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      if (wr) begin
         hwdata <= wd;
      end
      wait_rdy();
      check("bus response", 32'h0000_0000, {31'h0000_0000, hresp});
   endtask

   // load operands and flags, execute, then compare against own model
   task automatic run_op(input csx_op_e op, input logic [7:0] fv, input logic [7:0] w,
                         input logic [7:0] k, input logic [6:0] f, input logic d,
                         input logic [2:0] fl);
      logic [7:0] res;
      logic [7:0] sub;
      logic [2:0] efl;
      logic       tofile;
      xfer(1'b1, CSX_OFS_OPERAND, {15'h0000, d, 1'b0, f, k});
      xfer(1'b1, CSX_OFS_FILE, {24'h00_0000, fv});
      xfer(1'b1, CSX_OFS_ACC, {24'h00_0000, w});
      xfer(1'b1, CSX_OFS_STATUS, {29'h0000_0000, fl});
      xfer(1'b1, CSX_OFS_COMMAND, {29'h0000_0000, op});
      res = fv;
      efl = fl;
      sub = (op == CSX_OP_LIT_SUB) ? k : fv;
      case (op)
         CSX_OP_RRC: begin
            res    = {fl[0], fv[7:1]};
            efl[0] = fv[0];
         end
         CSX_OP_LIT_SUB, CSX_OP_FIL_SUB: begin
            res    = sub - w;
            efl[0] = (w <= sub);
            efl[1] = (w[3:0] <= sub[3:0]);
         end
         CSX_OP_XOR_F: res = w ^ fv;
         CSX_OP_XOR_L: res = w ^ k;
         CSX_OP_NIB_X: res = {fv[3:0], fv[7:4]};
         default: res = fv;
      endcase
      if (op inside {CSX_OP_LIT_SUB, CSX_OP_FIL_SUB, CSX_OP_XOR_F, CSX_OP_XOR_L}) begin
         efl[2] = (res == 8'h00);
      end
      tofile = d && (op inside {CSX_OP_RRC, CSX_OP_FIL_SUB, CSX_OP_XOR_F, CSX_OP_NIB_X});
      xfer(1'b0, CSX_OFS_ACC, 32'h0000_0000);
      check("accumulator", {24'h00_0000, tofile ? w : res}, rdv);
      xfer(1'b0, CSX_OFS_FILE, 32'h0000_0000);
      check("file", {24'h00_0000, tofile ? res : fv}, rdv);
      xfer(1'b0, CSX_OFS_STATUS, 32'h0000_0000);
      check("flags", {29'h0000_0000, efl}, {29'h0000_0000, rdv[2:0]});
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      xfer(1'b0, CSX_OFS_STATUS, 32'h0000_0000);
      check("status at reset", 32'h0000_0018, rdv);
      xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
      xfer(1'b0, 8'h40, 32'h0000_0000);
      check("unmapped", 32'h0000_0000, rdv);
      $display("test reset done");

      // flags preset opposite to what each op may touch, except carry in the 10h minus 01h literal subtract
      run_op(CSX_OP_RRC, 8'h6C, 8'h33, 8'h00, 7'h7F, 1'b0, 3'b111);
      run_op(CSX_OP_RRC, 8'h01, 8'h33, 8'h00, 7'h7F, 1'b1, 3'b000);
      run_op(CSX_OP_LIT_SUB, 8'h00, 8'h05, 8'h05, 7'h00, 1'b0, 3'b000);
      run_op(CSX_OP_LIT_SUB, 8'h00, 8'h01, 8'h10, 7'h01, 1'b1, 3'b111);
      run_op(CSX_OP_LIT_SUB, 8'h00, 8'h01, 8'h00, 7'h02, 1'b0, 3'b111);
      run_op(CSX_OP_FIL_SUB, 8'h3A, 8'h21, 8'h00, 7'h03, 1'b0, 3'b100);
      run_op(CSX_OP_FIL_SUB, 8'h20, 8'h21, 8'h00, 7'h7E, 1'b1, 3'b111);
      run_op(CSX_OP_FIL_SUB, 8'h44, 8'h44, 8'h00, 7'h05, 1'b1, 3'b000);
      run_op(CSX_OP_XOR_F, 8'hF0, 8'h0F, 8'h00, 7'h06, 1'b0, 3'b111);
      run_op(CSX_OP_XOR_F, 8'h5A, 8'h5A, 8'h00, 7'h07, 1'b1, 3'b011);
      run_op(CSX_OP_XOR_L, 8'h00, 8'hAA, 8'h55, 7'h08, 1'b1, 3'b111);
      run_op(CSX_OP_XOR_L, 8'h00, 8'h3C, 8'h3C, 7'h09, 1'b0, 3'b000);
      run_op(CSX_OP_NIB_X, 8'hA5, 8'h00, 8'h00, 7'h0A, 1'b0, 3'b101);
      run_op(CSX_OP_NIB_X, 8'h1E, 8'h00, 8'h00, 7'h0B, 1'b1, 3'b010);
      $display("test operations done");

      // awake overflow first drops the expiry flag, so sleep must raise it
      repeat (300) @(posedge mclk);
      xfer(1'b1, CSX_OFS_ACC, 32'h0000_005A);
      xfer(1'b1, CSX_OFS_OPERAND, 32'h0000_00FF);
      xfer(1'b1, CSX_OFS_COMMAND, {29'h0000_0000, CSX_OP_SLEEP});
      @(posedge mclk);
      check("halted", 32'h0000_0001, {31'h0000_0000, osc_halted});
      xfer(1'b0, CSX_OFS_WDOG, 32'h0000_0000);
      check("watchdog count", 32'h0000_0000, {24'h00_0000, rdv[7:0]});
      check("prescaler fresh", 32'h0000_0001, {31'h0000_0000, rdv[15:8] < 8'h08});
      xfer(1'b0, CSX_OFS_STATUS, 32'h0000_0000);
      check("sleep status", 32'h0000_0006, {29'h0000_0000, rdv[5:3]});
      xfer(1'b1, CSX_OFS_COMMAND, {29'h0000_0000, CSX_OP_XOR_L});
      xfer(1'b0, CSX_OFS_ACC, 32'h0000_0000);
      check("acc while asleep", 32'h0000_005A, rdv);
      xfer(1'b1, CSX_OFS_WAKE, 32'h0000_0001);
      @(posedge mclk);
      check("woken", 32'h0000_0000, {31'h0000_0000, osc_halted});
      xfer(1'b1, CSX_OFS_COMMAND, {29'h0000_0000, CSX_OP_XOR_L});
      xfer(1'b0, CSX_OFS_ACC, 32'h0000_0000);
      check("acc after wake", 32'h0000_00A5, rdv);
      // second sleep left to the watchdog to end
      xfer(1'b1, CSX_OFS_COMMAND, {29'h0000_0000, CSX_OP_SLEEP});
      repeat (300) @(posedge mclk);
      check("watchdog wake", 32'h0000_0000, {31'h0000_0000, osc_halted});
      xfer(1'b0, CSX_OFS_STATUS, 32'h0000_0000);
      check("wake status", 32'h0000_0000, {29'h0000_0000, rdv[5:3]});
      $display("test sleep done");
      conclude();
   end
endmodule // tb_cpu_sleep_sub_xor_swap_rotate_ops
